// ---- wlpc_asserts.sv ----
`timescale 1ns/1ns
module wlpc_asserts #(
	parameter int unsigned PRESC_CYCLES = wlpc_pkg::PRESC_OSC_CYC
) (
	// clock and reset
	input wire logic                     pclk,
	input wire logic                     presetn,
	input wire logic                     ce,
	// apb
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pslverr,
	// core side
	input wire wlpc_pkg::wlpc_core_evt_t core_evt,
	input wire logic                     wdg_reset_req,
	input wire wlpc_pkg::wlpc_halt_t     halt_mode
);
	// --------
	// checks
	// --------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_act_wake;
		halt_mode.active_halt && ce && (core_evt.tb_irq || core_evt.ext_irq);
	endsequence
	sequence s_full_wake;
		halt_mode.full_halt && ce && core_evt.ext_irq;
	endsequence
	one_mode_a:
	assert property (!(halt_mode.full_halt && halt_mode.active_halt)) else $error("both halt modes");
	full_entry_a:
	assert property ($rose(halt_mode.full_halt) |-> $past(core_evt.halt_req) && !wdg_reset_req)
		else $error("full halt without request");
	full_quiet_a:
	assert property (halt_mode.full_halt |-> !wdg_reset_req) else $error("reset in full halt");
	full_wake_a:
	assert property (s_full_wake |=> !halt_mode.full_halt) else $error("full halt not left");
	act_entry_a:
	assert property ($rose(halt_mode.active_halt) |-> $past(core_evt.halt_req) && !wdg_reset_req)
		else $error("active halt without request");
	act_quiet_a:
	assert property (halt_mode.active_halt |-> !wdg_reset_req) else $error("reset in active halt");
	act_wake_a:
	assert property (s_act_wake |=> !halt_mode.active_halt) else $error("active halt not left");
	pulse_once_a:
	assert property (wdg_reset_req |=> !wdg_reset_req) else $error("reset request too long");
	err_phase_a:
	assert property (pslverr |-> psel && penable) else $error("error outside access");
endmodule
bind wlpc_watchdog wlpc_asserts #(.PRESC_CYCLES(PRESC_CYCLES)) wlpc_asserts_inst (
	.pclk, .presetn, .ce, .psel, .penable, .pslverr, .core_evt, .wdg_reset_req, .halt_mode);

// ---- wlpc_core_model.sv ----
`timescale 1ns/1ns
module wlpc_core_model (
	// clock and reset
	input wire logic                     pclk,
	input wire logic                     presetn,
	// bench command and watchdog state
	input wire wlpc_pkg::wlpc_core_evt_t cmd,
	input wire wlpc_pkg::wlpc_halt_t     halt_mode,
	// one-cycle event pulses
	output wlpc_pkg::wlpc_core_evt_t     core_evt
);
	// --------
	// events
	// --------
	wlpc_pkg::wlpc_core_evt_t evt_reg;
	wlpc_pkg::wlpc_core_evt_t evt_next;
	always_comb begin
		evt_next = cmd;
		// a halted core fetches nothing, so it cannot halt again
		if (halt_mode != 2'h0)
			evt_next.halt_req = 1'b0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			evt_reg <= 3'h0;
		else
			evt_reg <= evt_next;
	end
	assign core_evt = evt_reg;
endmodule

// ---- wlpc_dummy_unused.sv ----
`timescale 1ns/1ns

// ---- wlpc_pkg.sv ----
package wlpc_pkg;

	// ------------------------------------------------------------------
	// register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------------
	localparam int          ADDR_W        = 12;
	localparam logic [11:0] OFF_CTRL      = 12'h000;
	localparam logic [11:0] OFF_STAT      = 12'h004;
	localparam logic [11:0] OFF_CFG       = 12'h008;

	// control word: activate bit over the seven-bit counter
	localparam int          CNT_W         = 7;
	localparam int          CTRL_ACT_BIT  = 7;
	localparam int          CTRL_TOP_BIT  = 6;
	localparam logic [6:0]  CNT_RESET     = 7'h7f;
	localparam logic [6:0]  CNT_EXPIRE    = 7'h40;
	localparam logic [6:0]  CNT_ONE       = 7'h01;

	// config word
	localparam int          CFG_TBIE_BIT  = 0;

	// status word fields
	localparam int          STAT_STATE_LO = 0;
	localparam int          STAT_STATE_HI = 4;
	localparam int          STAT_ACT_BIT  = 5;
	localparam int          STAT_HRST_BIT = 6;
	localparam int          STAT_HW_BIT   = 7;
	localparam int          STAT_LONG_BIT = 8;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int          PRESC_W       = 14;
	localparam int          PRESC_OSC_CYC = 16384;
	localparam int          CLK_MHZ       = 10;
	localparam int          DLY_W         = 12;
	// restart delays are given in cpu clocks, which are pclk cycles here
	localparam int          DLY_SHORT_CLK = 256;
	localparam int          DLY_LONG_CLK  = 4096;
	localparam logic [11:0] DLY_SHORT_CYC = 12'(DLY_SHORT_CLK - 1);
	localparam logic [11:0] DLY_LONG_CYC  = 12'(DLY_LONG_CLK - 1);

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		WLPC_RUN       = 5'h01,
		WLPC_FULL_LAST = 5'h02,
		WLPC_FULL_STOP = 5'h04,
		WLPC_ACT_HALT  = 5'h08,
		WLPC_RESTART   = 5'h10
	} wlpc_state_t;

	typedef struct packed {
		logic hw_watchdog;
		logic halt_reset_option;
		logic long_delay;
	} wlpc_opt_t;

	typedef struct packed {
		logic halt_req;
		logic ext_irq;
		logic tb_irq;
	} wlpc_core_evt_t;

	typedef struct packed {
		logic full_halt;
		logic active_halt;
	} wlpc_halt_t;

endpackage

// ---- wlpc_watchdog.sv ----
`timescale 1ns/1ns

module wlpc_watchdog #(
	parameter int unsigned PRESC_CYCLES = wlpc_pkg::PRESC_OSC_CYC
) (
	// clock, reset, enable
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        ce,
	// apb slave
	input  wire logic [wlpc_pkg::ADDR_W-1:0] paddr,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [31:0]                 pwdata,
	input  wire logic [3:0]                  pstrb,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// option straps and core power-mode events
	input  wire wlpc_pkg::wlpc_opt_t         opt_in,
	input  wire wlpc_pkg::wlpc_core_evt_t    core_evt,
	// to core reset and power control
	output logic                             wdg_reset_req,
	output wlpc_pkg::wlpc_halt_t             halt_mode
);

	// ------------------------------------------------------------------
	// constants
	// ------------------------------------------------------------------
	localparam logic [13:0] PRESC_LAST = 14'(PRESC_CYCLES - 1);

	function automatic logic [11:0] restart_delay(input logic long_sel);
		restart_delay = long_sel ? wlpc_pkg::DLY_LONG_CYC : wlpc_pkg::DLY_SHORT_CYC;
	endfunction

	// address match, shared by the error decode and the write strobes
	function automatic logic addr_is(input logic [wlpc_pkg::ADDR_W-1:0] a,
		input logic [wlpc_pkg::ADDR_W-1:0] off);
		addr_is = (a == off);
	endfunction

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	wlpc_pkg::wlpc_state_t state_reg;
	wlpc_pkg::wlpc_state_t state_next;
	logic [6:0]            cnt_reg;
	logic [6:0]            cnt_next;
	logic [13:0]           presc_reg;
	logic [13:0]           presc_next;
	logic [11:0]           dly_reg;
	logic [11:0]           dly_next;
	logic                  act_reg;
	logic                  act_next;
	logic                  tbie_reg;
	logic                  tbie_next;
	logic                  rst_reg;
	logic                  rst_next;
	wlpc_pkg::wlpc_opt_t   opt_reg;
	wlpc_pkg::wlpc_opt_t   opt_next;
	logic                  taken_reg;
	logic                  taken_next;
	logic [31:0]           rdata_reg;
	logic [31:0]           rdata_next;
	logic                  err_reg;
	logic                  err_next;

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------
	logic        setup;
	logic        access;
	logic        wr_ctrl;
	logic        wr_cfg;
	logic        hit;
	logic        active;
	logic        counting;
	logic        tick;
	logic [31:0] stat_word;

	assign setup    = psel & ~penable & ce;
	assign access   = psel & penable & ce;
	assign hit      = addr_is(paddr, wlpc_pkg::OFF_CTRL) | addr_is(paddr, wlpc_pkg::OFF_STAT)
		| addr_is(paddr, wlpc_pkg::OFF_CFG);
	assign wr_ctrl  = access & pwrite & pstrb[0] & addr_is(paddr, wlpc_pkg::OFF_CTRL);
	assign wr_cfg   = access & pwrite & pstrb[0] & addr_is(paddr, wlpc_pkg::OFF_CFG);
	assign active   = act_reg | opt_reg.hw_watchdog;
	assign counting = (state_reg == wlpc_pkg::WLPC_RUN) | (state_reg == wlpc_pkg::WLPC_FULL_LAST);
	assign tick     = (presc_reg == PRESC_LAST);

	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[wlpc_pkg::STAT_STATE_HI:wlpc_pkg::STAT_STATE_LO] = state_reg;
		stat_word[wlpc_pkg::STAT_ACT_BIT]  = active;
		stat_word[wlpc_pkg::STAT_HRST_BIT] = opt_reg.halt_reset_option;
		stat_word[wlpc_pkg::STAT_HW_BIT]   = opt_reg.hw_watchdog;
		stat_word[wlpc_pkg::STAT_LONG_BIT] = opt_reg.long_delay;
	end

	// ------------------------------------------------------------------
	// bus read path
	// ------------------------------------------------------------------
	// read data is captured in the setup cycle so it comes from flops;
	// the access phase always completes in one cycle while ce is high
	always_comb begin
		rdata_next = rdata_reg;
		err_next   = err_reg;
		if (setup) begin
			err_next   = ~hit;
			rdata_next = 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					wlpc_pkg::OFF_CTRL: begin
						rdata_next[wlpc_pkg::CTRL_ACT_BIT] = act_reg;
						rdata_next[wlpc_pkg::CNT_W-1:0]    = cnt_reg;
					end
					wlpc_pkg::OFF_STAT: begin
						rdata_next = stat_word;
					end
					wlpc_pkg::OFF_CFG: begin
						rdata_next[wlpc_pkg::CFG_TBIE_BIT] = tbie_reg;
					end
					default: begin
						rdata_next = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// watchdog core
	// ------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		presc_next = presc_reg;
		dly_next   = dly_reg;
		act_next   = act_reg;
		tbie_next  = tbie_reg;
		opt_next   = opt_reg;
		taken_next = 1'b1;
		rst_next   = 1'b0;

		// straps are caught in the first enabled cycle after release
		// straps are static: a later change is not seen until the next reset
		if (!taken_reg) begin
			opt_next = opt_in;
		end

		// only run and the last full-halt step reach this block; full stop, active halt and restart hold the count
		if (counting) begin
			presc_next = tick ? 14'h0000 : presc_reg + 14'h0001;
			if (tick) begin
				cnt_next = cnt_reg - wlpc_pkg::CNT_ONE;
			end
		end

		case (state_reg)
			wlpc_pkg::WLPC_RUN: begin
				if (active && tick && (cnt_reg == wlpc_pkg::CNT_EXPIRE)) begin
					rst_next = 1'b1;
				end
				// an expiry in the same cycle wins: the core is reset before it can halt
				if (core_evt.halt_req && !rst_next) begin
					if (tbie_reg) begin
						state_next = wlpc_pkg::WLPC_ACT_HALT;
					end else if (opt_reg.halt_reset_option) begin
						rst_next = 1'b1;
					end else begin
						state_next = wlpc_pkg::WLPC_FULL_LAST;
					end
				end
			end
			wlpc_pkg::WLPC_FULL_LAST: begin
				// one more decrement, then stop
				// no expiry check here: the final decrement never resets
				if (core_evt.ext_irq) begin
					state_next = wlpc_pkg::WLPC_RESTART;
					dly_next   = restart_delay(opt_reg.long_delay);
				end else if (tick) begin
					state_next = wlpc_pkg::WLPC_FULL_STOP;
				end
			end
			wlpc_pkg::WLPC_FULL_STOP: begin
				// external interrupt starts the restart delay
				if (core_evt.ext_irq) begin
					state_next = wlpc_pkg::WLPC_RESTART;
					dly_next   = restart_delay(opt_reg.long_delay);
				end
			end
			wlpc_pkg::WLPC_ACT_HALT: begin
				if (core_evt.tb_irq || core_evt.ext_irq) begin
					state_next = wlpc_pkg::WLPC_RUN;
				end
			end
			wlpc_pkg::WLPC_RESTART: begin
				// delayed restart after reset or after an external interrupt wakes a full halt
				// the block cannot tell which reset ended a halt, so every release pays the delay
				if (!taken_reg) begin
					dly_next = restart_delay(opt_in.long_delay);
				end else if (dly_reg == 12'h000) begin
					state_next = wlpc_pkg::WLPC_RUN;
				end else begin
					dly_next = dly_reg - 12'h001;
				end
			end
			default: begin
				state_next = wlpc_pkg::WLPC_RUN;
			end
		endcase

		// software refresh overrides the same-cycle decrement
		// outside run a write reloads the counter but never starts a reset
		if (wr_ctrl) begin
			cnt_next = pwdata[wlpc_pkg::CNT_W-1:0];
			if (pwdata[wlpc_pkg::CTRL_ACT_BIT]) begin
				act_next = 1'b1;
			end
			// writing with the top bit clear while active is a software reset
			if ((active || pwdata[wlpc_pkg::CTRL_ACT_BIT]) && !pwdata[wlpc_pkg::CTRL_TOP_BIT]
				&& (state_reg == wlpc_pkg::WLPC_RUN)) begin
				rst_next = 1'b1;
			end
		end
		if (wr_cfg) begin
			tbie_next = pwdata[wlpc_pkg::CFG_TBIE_BIT];
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// reset comes up disabled; hardware option re-applied from straps
			state_reg <= wlpc_pkg::WLPC_RESTART;
			cnt_reg   <= wlpc_pkg::CNT_RESET;
			presc_reg <= 14'h0000;
			dly_reg   <= 12'h000;
			act_reg   <= 1'b0;
			tbie_reg  <= 1'b0;
			opt_reg   <= '0;
			taken_reg <= 1'b0;
			rst_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			err_reg   <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			presc_reg <= presc_next;
			dly_reg   <= dly_next;
			act_reg   <= act_next;
			tbie_reg  <= tbie_next;
			opt_reg   <= opt_next;
			taken_reg <= taken_next;
			rst_reg   <= rst_next;
			rdata_reg <= rdata_next;
			err_reg   <= err_next;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	// a frozen block must not complete transfers it cannot register
	// limitation: a master with its own bus timeout will give up on a frozen block
	assign pready                = ce;
	assign prdata                = rdata_reg;
	assign pslverr               = err_reg & access;
	assign wdg_reset_req         = rst_reg;
	// halt flags decode straight from the one-hot state flops, so they never glitch
	assign halt_mode.full_halt   = (state_reg == wlpc_pkg::WLPC_FULL_LAST) | (state_reg == wlpc_pkg::WLPC_FULL_STOP);
	assign halt_mode.active_halt = (state_reg == wlpc_pkg::WLPC_ACT_HALT);

endmodule

// ---- wlpc_watchdog_tb_top.sv ----
`timescale 1ns/1ns
module wlpc_watchdog_tb_top;
	// --------
	// bench
	// --------
	localparam logic [11:0] CT = wlpc_pkg::OFF_CTRL;
	localparam logic [11:0] ST = wlpc_pkg::OFF_STAT;
	localparam logic [11:0] CF = wlpc_pkg::OFF_CFG;
	logic                     pclk    = 1'b0;
	logic                     presetn = 1'b0;
	logic                     ce      = 1'b1;
	logic [11:0]              paddr   = 12'h0;
	logic                     psel    = 1'b0;
	logic                     penable = 1'b0;
	logic                     pwrite  = 1'b0;
	logic [31:0]              pwdata  = 32'h0;
	logic [3:0]               pstrb   = 4'hf;
	logic [31:0]              prdata, q, v1;
	logic                     pready, pslverr, wdg_reset_req, e;
	wlpc_pkg::wlpc_opt_t      opt_in  = 3'h0;
	wlpc_pkg::wlpc_core_evt_t cmd     = 3'h0;
	wlpc_pkg::wlpc_core_evt_t core_evt;
	wlpc_pkg::wlpc_halt_t     halt_mode;
	int n_mismatch = 0;
	int n_compared = 0;
	int n_rst = 0;
	int cyc = 0;
	int r0;
	wlpc_watchdog #(.PRESC_CYCLES(16)) wlpc_watchdog_inst (.pclk, .presetn, .ce, .paddr, .psel, .penable,
		.pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .opt_in, .core_evt, .wdg_reset_req, .halt_mode);
	wlpc_core_model wlpc_core_model_inst (.pclk, .presetn, .cmd, .halt_mode, .core_evt);
	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (wdg_reset_req === 1'b1)
			n_rst++;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end
	task complete_run;
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			$display("BAD %s exp %h got %h", n, x, g);
			n_mismatch++;
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	// requests held until pready is seen high at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task ev(input wlpc_pkg::wlpc_core_evt_t k);
		@(posedge pclk);
		cmd <= k;
		@(posedge pclk);
		cmd <= 3'h0;
		wt(2);
	endtask
	task rst(input wlpc_pkg::wlpc_opt_t o);
		@(posedge pclk);
		presetn <= 1'b0;
		opt_in <= o;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	initial begin
		rst(3'h0);
		apb(0, CT, 0); chk("ctrl_rst", 32'h7f, q);
		apb(1, ST, 32'hff); apb(0, ST, 0); chk("stat_rst", 32'h10, q);
		apb(0, CF, 0); chk("cfg_rst", 32'h0, q);
		apb(0, 12'h00c, 0); chk("unmap_err", 32'h1, e);
		wt(300);
		apb(1, CT, 32'h70); wt(64); apb(0, CT, 0); chk("free_run", 1, q >= 32'h6b && q <= 32'h6c);
		r0 = n_rst; apb(1, CT, 32'h41); wt(48); chk("off_no_rst", r0, n_rst);
		apb(1, CT, 32'hc2); r0 = n_rst; wt(20); chk("early", r0, n_rst);
		wt(34); chk("expire", r0 + 1, n_rst);
		apb(1, CT, 32'h7f); apb(0, CT, 0); chk("act_sticky", 32'h80, q & 32'h80);
		apb(1, CF, 0); apb(1, CT, 32'hff); ev(3'b100); chk("full", 2'b10, halt_mode);
		r0 = n_rst; wt(32); apb(0, CT, 0); v1 = q; chk("last_dec", 1, v1 >= 32'hfd && v1 <= 32'hfe);
		wt(64); apb(0, CT, 0); chk("frozen", v1, q); chk("full_no_rst", r0, n_rst);
		ev(3'b010); chk("wake", 2'b00, halt_mode); wt(200); apb(0, CT, 0); chk("hold", v1, q);
		wt(100); apb(0, CT, 0); chk("resume", 1, q < v1);
		for (int k = 0; k < 2; k++) begin
			apb(1, CT, 32'hff); apb(1, CF, 1); ev(3'b100); chk("act", 2'b01, halt_mode);
			apb(0, CT, 0); v1 = q; wt(64); apb(0, CT, 0); chk("act_hold", v1, q);
			ev(k ? 3'b010 : 3'b001); chk("act_wake", 2'b00, halt_mode);
			wt(40); apb(0, CT, 0); chk("act_resume", 1, q < v1);
		end
		apb(1, CF, 0); ev(3'b100); chk("full_again", 2'b10, halt_mode);
		rst(3'b010); wt(300); apb(0, CT, 0); chk("full_rst_off", 32'h0, q & 32'h80);
		apb(1, CF, 0); r0 = n_rst;
		ev(3'b100); chk("halt_rst", r0 + 1, n_rst); chk("no_halt", 2'b00, halt_mode);
		apb(1, CF, 1); ev(3'b100); chk("act_any", 2'b01, halt_mode); chk("act_no_rst", r0 + 1, n_rst);
		ev(3'b001);
		rst(3'b101); apb(0, ST, 0); chk("hw_stat", 32'h1b0, q);
		wt(3900); apb(0, CT, 0); chk("long_hold", 32'h7f, q & 32'h7f);
		wt(400); apb(0, CT, 0); chk("long_run", 1, (q & 32'h7f) < 32'h7f);
		r0 = n_rst; apb(1, CT, 32'h41); wt(40); chk("hw_expire", r0 + 1, n_rst);
		apb(0, CT, 0); v1 = q; @(posedge pclk); ce <= 1'b0; wt(64); chk("ce_stall", 0, pready);
		@(posedge pclk); ce <= 1'b1; apb(0, CT, 0); chk("ce_freeze", 1, v1 - q <= 32'h1);
		complete_run();
	end
endmodule
